/* File: logic/fbo_regs.svh */
// register offsets, field positions, reset values and event layout
`ifndef FBO_REGS_SVH
`define FBO_REGS_SVH

`define FBO_AW          8
`define FBO_OFS_IMM     8'h00
`define FBO_OFS_SYNC    8'h04
`define FBO_OFS_EXIT    8'h08
`define FBO_OFS_FILTER  8'h0c
`define FBO_OFS_STATUS  8'h10
`define FBO_OFS_STICKY  8'h14

`define FBO_IMM_RST     8'hc7
`define FBO_SYNC_RST    8'ha0
`define FBO_EXIT_RST    8'h64
`define FBO_LVL_MAX     8'hc8
`define FBO_PCT_FULL    7'h64

`define FBO_ST_PCT_MSB  6
`define FBO_ST_IMM      8
`define FBO_ST_SYNC     9

`define FBO_EVT_ID_MSB  15
`define FBO_EVT_RSV_LSB 16
`define FBO_EVT_RSV_MSB 31
`define FBO_EVT_MASK    32
`define FBO_MASK_CUT    0
`define FBO_MASK_DROP   1
`define FBO_MASK_GOOD   2
`define FBO_EVT_TS_LSB  48
`define FBO_EVT_TS_MSB  63

`define FBO_RESP_OKAY   2'h0
`define FBO_RESP_SLVERR 2'h2

`endif

/* File: logic/fbo_pkg.sv */
// shared types of the frame buffer overflow manager
package fbo_pkg;

	typedef enum logic [3:0] {
		FBO_FRM_IDLE = 4'h1,
		FBO_FRM_PASS = 4'h2,
		FBO_FRM_CUT  = 4'h4,
		FBO_FRM_DROP = 4'h8
	} fbo_frm_e;

	typedef enum logic [2:0] {
		FBO_REPORT_CUT            = 3'h0,
		FBO_REPORT_DROPPED        = 3'h1,
		FBO_REPORT_CUT_OR_DROPPED = 3'h2,
		FBO_REPORT_GOOD           = 3'h3,
		FBO_REPORT_CUT_OR_GOOD    = 3'h4,
		FBO_REPORT_DROPPED_OR_GOOD = 3'h5,
		FBO_REPORT_ALL            = 3'h6
	} fbo_filter_e;

endpackage : fbo_pkg

/* File: logic/fbo_axil.sv */
// axi4-lite slave front end: holds address and data, issues strobes
`timescale 1ns/1ps
`include "fbo_regs.svh"

module fbo_axil #(
	parameter int AW = `FBO_AW
) (
	// system
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// axi4-lite
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	output logic [1:0]         s_axi_bresp,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	input  wire logic [AW-1:0] s_axi_araddr,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	// register file side
	output logic               wr_en,
	output logic [AW-1:0]      wr_addr,
	output logic [31:0]        wr_data,
	output logic [3:0]         wr_strb,
	input  wire logic          wr_err,
	output logic               rd_en,
	output logic [AW-1:0]      rd_addr,
	input  wire logic [31:0]   rd_data,
	input  wire logic          rd_err
);

	typedef struct packed {
		logic          aw_h;
		logic          w_h;
		logic [AW-1:0] awaddr;
		logic [31:0]   wdata;
		logic [3:0]    wstrb;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          rvalid;
		logic [31:0]   rdata;
		logic [1:0]    rresp;
	} fbo_axil_s;

	fbo_axil_s r;
	fbo_axil_s next_r;

	// no new write is taken while a response waits
	assign s_axi_awready = !r.aw_h && !r.bvalid;
	assign s_axi_wready  = !r.w_h && !r.bvalid;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_rvalid  = r.rvalid;
	assign s_axi_rdata   = r.rdata;
	assign s_axi_rresp   = r.rresp;
	assign wr_en   = r.aw_h && r.w_h && !r.bvalid;
	assign wr_addr = r.awaddr;
	assign wr_data = r.wdata;
	assign wr_strb = r.wstrb;
	assign rd_en   = s_axi_arvalid && !r.rvalid;
	assign rd_addr = s_axi_araddr;

	always_comb
	begin
		next_r = r;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_r.aw_h   = 1'b1;
			next_r.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_r.w_h   = 1'b1;
			next_r.wdata = s_axi_wdata;
			next_r.wstrb = s_axi_wstrb;
		end
		if (wr_en)
		begin
			next_r.aw_h   = 1'b0;
			next_r.w_h    = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp  = wr_err ? `FBO_RESP_SLVERR : `FBO_RESP_OKAY;
		end
		else if (r.bvalid && s_axi_bready)
			next_r.bvalid = 1'b0;
		if (rd_en)
		begin
			next_r.rvalid = 1'b1;
			next_r.rdata  = rd_data;
			next_r.rresp  = rd_err ? `FBO_RESP_SLVERR : `FBO_RESP_OKAY;
		end
		else if (r.rvalid && s_axi_rready)
			next_r.rvalid = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r <= '0;
		else
			r <= next_r;
	end

	property p_bvalid_hold;
		@(posedge aclk) disable iff (!aresetn)
		r.bvalid && !s_axi_bready |=> r.bvalid && $stable(r.bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold)
		else $error("write response dropped before bready");

	property p_rvalid_hold;
		@(posedge aclk) disable iff (!aresetn)
		r.rvalid && !s_axi_rready |=> r.rvalid && $stable(r.rdata);
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold)
		else $error("read data changed before rready");

endmodule : fbo_axil

/* File: logic/fbo_overflow_ctrl.sv */
// overflow manager: frame admission, truncation, events and registers
`timescale 1ns/1ps
`include "fbo_regs.svh"

module fbo_overflow_ctrl #(
	parameter int DW        = 32,
	parameter int FILL_W    = 16,
	parameter int BUF_DEPTH = 4096
) (
	// system
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite register bus
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [`FBO_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [`FBO_AW-1:0] s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// camera stream
	input  wire logic              cam_valid,
	input  wire logic              cam_sof,
	input  wire logic              cam_eof,
	input  wire logic [15:0]       cam_frame_number,
	input  wire logic [DW-1:0]     cam_data,
	// frame buffer write side
	input  wire logic [FILL_W-1:0] buf_fill,
	output logic                   buf_wr_valid,
	output logic [DW-1:0]          buf_wr_data,
	output logic                   buf_wr_last,
	output logic                   buf_wr_cut,
	// status events
	output logic                   evt_valid,
	output logic [63:0]            evt_data
);

	localparam int PW = FILL_W + 8;

	typedef struct packed {
		fbo_pkg::fbo_frm_e    frm;
		logic                 imm_ovf;
		logic                 sync_ovf;
		logic                 sticky;
		logic [7:0]           imm_lvl;
		logic [7:0]           sync_lvl;
		logic [7:0]           exit_lvl;
		fbo_pkg::fbo_filter_e filter;
		logic [15:0]          frame_id;
		logic [15:0]          stamp;
		logic                 wr_valid;
		logic [DW-1:0]        wr_data;
		logic                 wr_last;
		logic                 wr_cut;
		logic                 evt_valid;
		logic [63:0]          evt_data;
	} fbo_core_s;

	fbo_core_s r;
	fbo_core_s next_r;

	logic                wr_en;
	logic [`FBO_AW-1:0]  wr_addr;
	logic [31:0]         wr_data;
	logic [3:0]          wr_strb;
	logic                rd_en;
	logic [`FBO_AW-1:0]  rd_addr;
	logic [31:0]         rd_data;
	logic [PW-1:0]       fill_x100;
	logic [PW-1:0]       pct_raw;
	logic [6:0]          occ_pct;
	logic [7:0]          occ_lvl;
	logic                fin;
	logic                fcut;
	logic                fdrop;
	logic [15:0]         id_now;

	function automatic logic fbo_hit(input logic [`FBO_AW-1:0] a);
		return a == `FBO_OFS_IMM || a == `FBO_OFS_SYNC ||
			a == `FBO_OFS_EXIT || a == `FBO_OFS_FILTER ||
			a == `FBO_OFS_STATUS || a == `FBO_OFS_STICKY;
	endfunction : fbo_hit

	// levels above 100.0 percent are held at full scale
	function automatic logic [7:0] fbo_clip(input logic [7:0] v);
		return (v > `FBO_LVL_MAX) ? `FBO_LVL_MAX : v;
	endfunction : fbo_clip

	function automatic logic fbo_pass(input fbo_pkg::fbo_filter_e f,
		input logic cut, input logic drop, input logic good);
		case (f)
			fbo_pkg::FBO_REPORT_CUT:             return cut;
			fbo_pkg::FBO_REPORT_DROPPED:         return drop;
			fbo_pkg::FBO_REPORT_CUT_OR_DROPPED:  return cut || drop;
			fbo_pkg::FBO_REPORT_GOOD:            return good;
			fbo_pkg::FBO_REPORT_CUT_OR_GOOD:     return cut || good;
			fbo_pkg::FBO_REPORT_DROPPED_OR_GOOD: return drop || good;
			fbo_pkg::FBO_REPORT_ALL:             return 1'b1;
			default:                             return 1'b0;
		endcase
	endfunction : fbo_pass

	function automatic logic [63:0] fbo_word(input logic [15:0] id,
		input logic [15:0] ts, input logic cut, input logic drop,
		input logic good);
		logic [63:0] w;
		w = '0;
		w[`FBO_EVT_ID_MSB:0] = id;
		w[`FBO_EVT_MASK + `FBO_MASK_CUT]  = cut;
		w[`FBO_EVT_MASK + `FBO_MASK_DROP] = drop;
		w[`FBO_EVT_MASK + `FBO_MASK_GOOD] = good;
		w[`FBO_EVT_TS_MSB:`FBO_EVT_TS_LSB] = ts;
		return w;
	endfunction : fbo_word

	fbo_axil #(
		.AW (`FBO_AW)
	) u_axil (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_err        (!fbo_hit(wr_addr)),
		.rd_en         (rd_en),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_err        (!fbo_hit(rd_addr))
	);

	// integer percent; a fill above depth still reads 100
	assign fill_x100 = PW'(buf_fill) * PW'(`FBO_PCT_FULL);
	assign pct_raw   = fill_x100 / PW'(BUF_DEPTH);
	assign occ_pct   = (pct_raw > PW'(`FBO_PCT_FULL)) ?
		`FBO_PCT_FULL : pct_raw[6:0];
	// levels are kept in half-percent steps
	assign occ_lvl   = {occ_pct, 1'b0};

	always_comb
	begin
		rd_data = '0;
		case (rd_addr)
			`FBO_OFS_IMM:    rd_data[7:0] = r.imm_lvl;
			`FBO_OFS_SYNC:   rd_data[7:0] = r.sync_lvl;
			`FBO_OFS_EXIT:   rd_data[7:0] = r.exit_lvl;
			`FBO_OFS_FILTER: rd_data[2:0] = r.filter;
			`FBO_OFS_STATUS:
			begin
				rd_data[`FBO_ST_PCT_MSB:0] = occ_pct;
				rd_data[`FBO_ST_IMM]       = r.imm_ovf;
				rd_data[`FBO_ST_SYNC]      = r.sync_ovf;
			end
			`FBO_OFS_STICKY: rd_data[0] = r.sticky;
			default:         rd_data = '0;
		endcase
	end

	always_comb
	begin
		next_r = r;
		fin    = 1'b0;
		fcut   = 1'b0;
		fdrop  = 1'b0;
		id_now = r.frame_id;
		next_r.wr_valid  = 1'b0;
		next_r.wr_last   = 1'b0;
		next_r.wr_cut    = 1'b0;
		next_r.evt_valid = 1'b0;
		next_r.stamp     = r.stamp + 16'h1;
		if (wr_en && wr_strb[0])
		begin
			case (wr_addr)
				`FBO_OFS_IMM:    next_r.imm_lvl  = fbo_clip(wr_data[7:0]);
				`FBO_OFS_SYNC:   next_r.sync_lvl = fbo_clip(wr_data[7:0]);
				`FBO_OFS_EXIT:   next_r.exit_lvl = fbo_clip(wr_data[7:0]);
				`FBO_OFS_FILTER:
					next_r.filter = fbo_pkg::fbo_filter_e'(wr_data[2:0]);
				default: ;
			endcase
		end
		// the read clears first so that a new overflow still wins
		if (rd_en && rd_addr == `FBO_OFS_STICKY)
			next_r.sticky = 1'b0;
		if (occ_lvl > r.imm_lvl)
		begin
			next_r.imm_ovf = 1'b1;
			next_r.sticky  = 1'b1;
		end
		else if (occ_lvl < r.exit_lvl)
			next_r.imm_ovf = 1'b0;
		// same level for entry and exit; entry checked only between frames, exit at any time
		if (occ_lvl < r.sync_lvl)
			next_r.sync_ovf = 1'b0;
		else if (r.frm == fbo_pkg::FBO_FRM_IDLE && occ_lvl > r.sync_lvl)
		begin
			next_r.sync_ovf = 1'b1;
			next_r.sticky   = 1'b1;
		end
		if (cam_valid)
		begin
			unique case (r.frm)
				fbo_pkg::FBO_FRM_IDLE:
				begin
					// beats outside a frame are ignored
					if (cam_sof)
					begin
						next_r.frame_id = cam_frame_number;
						id_now = cam_frame_number;
						fin = cam_eof;
						if (r.imm_ovf || r.sync_ovf)
						begin
							fdrop = 1'b1;
							next_r.frm = cam_eof ? fbo_pkg::FBO_FRM_IDLE :
								fbo_pkg::FBO_FRM_DROP;
						end
						else
						begin
							next_r.wr_valid = 1'b1;
							next_r.wr_data  = cam_data;
							next_r.wr_last  = cam_eof;
							next_r.frm = cam_eof ? fbo_pkg::FBO_FRM_IDLE :
								fbo_pkg::FBO_FRM_PASS;
						end
					end
				end
				fbo_pkg::FBO_FRM_PASS:
				begin
					fin = cam_eof;
					if (r.imm_ovf)
					begin
						// close the stored part so it still reaches the host
						next_r.wr_valid = 1'b1;
						next_r.wr_last  = 1'b1;
						next_r.wr_cut   = 1'b1;
						fcut = 1'b1;
						next_r.frm = cam_eof ? fbo_pkg::FBO_FRM_IDLE :
							fbo_pkg::FBO_FRM_CUT;
					end
					else
					begin
						next_r.wr_valid = 1'b1;
						next_r.wr_data  = cam_data;
						next_r.wr_last  = cam_eof;
						if (cam_eof)
							next_r.frm = fbo_pkg::FBO_FRM_IDLE;
					end
				end
				fbo_pkg::FBO_FRM_CUT:
				begin
					fcut = 1'b1;
					fin  = cam_eof;
					if (cam_eof)
						next_r.frm = fbo_pkg::FBO_FRM_IDLE;
				end
				fbo_pkg::FBO_FRM_DROP:
				begin
					fdrop = 1'b1;
					fin   = cam_eof;
					if (cam_eof)
						next_r.frm = fbo_pkg::FBO_FRM_IDLE;
				end
				default: next_r.frm = fbo_pkg::FBO_FRM_IDLE;
			endcase
		end
		// at most one event per frame end, so order follows arrival
		if (fin && fbo_pass(r.filter, fcut, fdrop, !fcut && !fdrop))
		begin
			next_r.evt_valid = 1'b1;
			next_r.evt_data  = fbo_word(id_now, r.stamp, fcut, fdrop,
				!fcut && !fdrop);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r          <= '0;
			r.frm      <= fbo_pkg::FBO_FRM_IDLE;
			r.imm_lvl  <= `FBO_IMM_RST;
			r.sync_lvl <= `FBO_SYNC_RST;
			r.exit_lvl <= `FBO_EXIT_RST;
			r.filter   <= fbo_pkg::FBO_REPORT_CUT_OR_DROPPED;
		end
		else
			r <= next_r;
	end

	assign buf_wr_valid = r.wr_valid;
	assign buf_wr_data  = r.wr_data;
	assign buf_wr_last  = r.wr_last;
	assign buf_wr_cut   = r.wr_cut;
	assign evt_valid    = r.evt_valid;
	assign evt_data     = r.evt_data;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_pass_hit;
		r.frm == fbo_pkg::FBO_FRM_PASS && r.imm_ovf && cam_valid;
	endsequence

	sequence s_cut_close;
		buf_wr_valid && buf_wr_cut && buf_wr_last;
	endsequence

	sequence s_drop_end;
		r.frm == fbo_pkg::FBO_FRM_DROP && cam_valid && cam_eof;
	endsequence

	property p_imm_entry;
		occ_lvl > r.imm_lvl |=> r.imm_ovf && r.sticky;
	endproperty
	a_imm_entry: assert property (p_imm_entry)
		else $error("no overflow above immediate level");

	property p_cut_now;
		s_pass_hit |=> s_cut_close ##0 (r.frm != fbo_pkg::FBO_FRM_PASS);
	endproperty
	a_cut_now: assert property (p_cut_now)
		else $error("frame not cut when overflow hit");

	property p_cut_tag;
		buf_wr_cut |-> buf_wr_last && buf_wr_valid;
	endproperty
	a_cut_tag: assert property (p_cut_tag)
		else $error("incomplete tag without closing beat");

	property p_sync_entry;
		r.frm == fbo_pkg::FBO_FRM_IDLE && occ_lvl > r.sync_lvl
			|=> r.sync_ovf;
	endproperty
	a_sync_entry: assert property (p_sync_entry)
		else $error("no overflow above frame boundary level");

	property p_sync_drop;
		r.sync_ovf && r.frm == fbo_pkg::FBO_FRM_IDLE && cam_valid &&
			cam_sof && !cam_eof |=> r.frm == fbo_pkg::FBO_FRM_DROP;
	endproperty
	a_sync_drop: assert property (p_sync_drop)
		else $error("frame not dropped in boundary overflow");

	property p_sync_exit;
		occ_lvl < r.sync_lvl |=> !r.sync_ovf;
	endproperty
	a_sync_exit: assert property (p_sync_exit)
		else $error("boundary overflow held below its level");

	property p_filter_cut;
		s_drop_end ##0 (r.filter == fbo_pkg::FBO_REPORT_CUT) |=> !evt_valid;
	endproperty
	a_filter_cut: assert property (p_filter_cut)
		else $error("dropped frame reported in cut only mode");

	property p_filter_all;
		s_drop_end ##0 (r.filter == fbo_pkg::FBO_REPORT_ALL)
			|=> evt_valid && evt_data[`FBO_EVT_MASK + `FBO_MASK_DROP];
	endproperty
	a_filter_all: assert property (p_filter_all)
		else $error("dropped frame not reported in all mode");

	property p_frame_id;
		r.frm == fbo_pkg::FBO_FRM_IDLE && cam_valid && cam_sof &&
			cam_eof && r.filter == fbo_pkg::FBO_REPORT_ALL |=> evt_valid &&
			evt_data[`FBO_EVT_ID_MSB:0] == $past(cam_frame_number);
	endproperty
	a_frame_id: assert property (p_frame_id)
		else $error("event frame number mismatch");

	property p_reserved;
		evt_valid |-> evt_data[`FBO_EVT_RSV_MSB:`FBO_EVT_RSV_LSB] == '0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved event bits set");

	property p_drop_silent;
		r.frm == fbo_pkg::FBO_FRM_DROP |=> !buf_wr_valid;
	endproperty
	a_drop_silent: assert property (p_drop_silent)
		else $error("write issued for dropped frame");

	property p_exclusive;
		evt_valid |-> !(evt_data[`FBO_EVT_MASK + `FBO_MASK_CUT] &&
			evt_data[`FBO_EVT_MASK + `FBO_MASK_DROP]);
	endproperty
	a_exclusive: assert property (p_exclusive)
		else $error("cut and dropped in one event");

	property p_imm_exit;
		r.imm_ovf && occ_lvl < r.exit_lvl && occ_lvl <= r.imm_lvl
			|=> !r.imm_ovf;
	endproperty
	a_imm_exit: assert property (p_imm_exit)
		else $error("overflow held below exit level");

endmodule : fbo_overflow_ctrl

/* File: test/fbo_cam_model.sv */
// camera frame source and frame buffer occupancy model
`timescale 1ns/1ps

module fbo_cam_model (
	// system
	input  wire logic   aclk,
	// camera stream
	output logic        cam_valid,
	output logic        cam_sof,
	output logic        cam_eof,
	output logic [15:0] cam_frame_number,
	output logic [31:0] cam_data,
	// frame buffer side
	output logic [15:0] buf_fill,
	input  wire logic   buf_wr_valid,
	input  wire logic [31:0] buf_wr_data,
	input  wire logic   buf_wr_last,
	input  wire logic   buf_wr_cut
);
	int wr_n = 0;
	int cut_n = 0;
	logic [31:0] last_word = 32'h0000_0000;

	initial
	begin
		cam_valid = 1'b0;
		cam_sof = 1'b0;
		cam_eof = 1'b0;
		cam_frame_number = 16'h0000;
		cam_data = 32'h0000_0000;
		buf_fill = 16'h0000;
	end

	// the number is scrambled off the sof beat so a stale value never helps
	task automatic send(input logic [15:0] n, input int beats, input int at,
		input logic [15:0] f);
		for (int i = 0; i < beats; i++)
		begin
			@(posedge aclk);
			if (i == at)
				buf_fill <= f;
			cam_valid        <= 1'b1;
			cam_sof          <= (i == 0);
			cam_eof          <= (i == beats - 1);
			cam_frame_number <= (i == 0) ? n : ~n;
			cam_data         <= {n, 16'(i)};
		end
		@(posedge aclk);
		cam_valid        <= 1'b0;
		cam_sof          <= 1'b0;
		cam_eof          <= 1'b0;
		cam_frame_number <= ~cam_frame_number;
		cam_data         <= ~cam_data;
	endtask : send

	// registered outputs are settled at the falling edge
	always @(negedge aclk)
	begin
		if (buf_wr_valid === 1'b1)
			wr_n++;
		if ((buf_wr_valid & buf_wr_last & buf_wr_cut) === 1'b1)
			cut_n++;
		// the closing beat of a cut frame carries no new data
		if ((buf_wr_valid & buf_wr_last & ~buf_wr_cut) === 1'b1)
			last_word = buf_wr_data;
	end
endmodule : fbo_cam_model

/* File: test/tb_frame_buffer_overflow_control.sv */
// self-checking bench for the overflow manager
`timescale 1ns/1ps
`include "fbo_regs.svh"

module tb_frame_buffer_overflow_control;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, cam_data, buf_wr_data;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        cam_valid, cam_sof, cam_eof, evt_valid;
	logic        buf_wr_valid, buf_wr_last, buf_wr_cut;
	logic [15:0] cam_frame_number, buf_fill, ev_ts;
	logic [63:0] evt_data, ev;
	int          ev_n, error_cnt, tests_run, cyc;

	fbo_overflow_ctrl #(.BUF_DEPTH(16)) dut (
		.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .cam_valid, .cam_sof, .cam_eof,
		.cam_frame_number, .cam_data, .buf_fill, .buf_wr_valid,
		.buf_wr_data, .buf_wr_last, .buf_wr_cut, .evt_valid, .evt_data);

	fbo_cam_model cam (
		.aclk, .cam_valid, .cam_sof, .cam_eof, .cam_frame_number,
		.cam_data, .buf_fill, .buf_wr_valid, .buf_wr_data, .buf_wr_last,
		.buf_wr_cut);

	task automatic summarize();
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// ready is judged at the falling edge, where it is stable until the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, bv;
		logic [1:0] r;
		bv = 1'b0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!bv)
		begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			bv = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk({30'h0, r}, {30'h0, `FBO_RESP_OKAY});
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic ta, rv;
		logic [31:0] d;
		logic [1:0] r;
		rv = 1'b0;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		while (!rv)
		begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			rv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(d, e);
		chk({30'h0, r}, {30'h0, er});
	endtask : rdchk

	// w below zero leaves the write count unchecked
	task automatic frame(input logic [15:0] n, input int beats, input int at,
		input logic [2:0] m, input int e, input int w);
		int e0, w0;
		e0 = ev_n;
		w0 = cam.wr_n;
		cam.send(n, beats, at, 16'h0010);
		repeat (3) @(posedge aclk);
		chk(32'(ev_n - e0), 32'(e));
		if (w >= 0)
			chk(32'(cam.wr_n - w0), 32'(w));
		if (e == 1)
			chk({16'h0, ev[15:0]}, {16'h0, n});
		if (e == 1)
			chk(ev[47:16], {13'h0, m, 16'h0});
		if (e == 1)
			chk({16'h0, ev[63:48]}, {16'h0, ev_ts});
		if (w == beats)
			chk(cam.last_word, {n, 16'(beats - 1)});
	endtask : frame

	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	always @(negedge aclk)
	begin
		if (evt_valid === 1'b1)
		begin
			ev_n++;
			ev = evt_data;
			// the stamp counts edges from the third edge of the run
			ev_ts = 16'(cyc - 3);
		end
	end

	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			summarize();
		end
	end

	initial
	begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr} = 16'h0000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdchk(`FBO_OFS_IMM, 32'hc7, `FBO_RESP_OKAY);
		rdchk(`FBO_OFS_SYNC, 32'ha0, `FBO_RESP_OKAY);
		rdchk(`FBO_OFS_EXIT, 32'h64, `FBO_RESP_OKAY);
		rdchk(`FBO_OFS_FILTER, 32'h2, `FBO_RESP_OKAY);
		rdchk(8'h20, 32'h0, `FBO_RESP_SLVERR);
		wr(`FBO_OFS_IMM, 32'hff);
		rdchk(`FBO_OFS_IMM, 32'hc8, `FBO_RESP_OKAY);
		wr(`FBO_OFS_IMM, 32'hc7);
		for (int i = 0; i < 8; i++)
		begin
			wr(`FBO_OFS_FILTER, 32'(i));
			frame(16'(i), 2, -1, 3'h4, (i >= 3 && i <= 6) ? 1 : 0, 2);
		end
		wr(`FBO_OFS_FILTER, 32'h6);
		frame(16'hffff, 1, -1, 3'h4, 1, 1);
		frame(16'h0000, 3, -1, 3'h4, 1, 3);
		// 14 of 16 entries is 87 percent: above the boundary level only
		wr(`FBO_OFS_FILTER, 32'h1);
		cam.buf_fill <= 16'h000e;
		repeat (4) @(posedge aclk);
		rdchk(`FBO_OFS_STATUS, 32'h257, `FBO_RESP_OKAY);
		frame(16'h0010, 3, -1, 3'h2, 1, 0);
		cam.buf_fill <= 16'h0004;
		repeat (4) @(posedge aclk);
		rdchk(`FBO_OFS_STICKY, 32'h1, `FBO_RESP_OKAY);
		rdchk(`FBO_OFS_STICKY, 32'h0, `FBO_RESP_OKAY);
		frame(16'h0011, 3, -1, 3'h4, 0, 3);
		wr(`FBO_OFS_FILTER, 32'h0);
		frame(16'h0020, 8, 2, 3'h1, 1, 4);
		chk(32'(cam.cut_n), 32'h1);
		// 75 percent: under the boundary level, not yet under the exit level
		wr(`FBO_OFS_FILTER, 32'h1);
		cam.buf_fill <= 16'h000c;
		repeat (4) @(posedge aclk);
		frame(16'h0022, 2, -1, 3'h2, 1, 0);
		wr(`FBO_OFS_FILTER, 32'h0);
		frame(16'h0024, 2, -1, 3'h2, 0, 0);
		wr(`FBO_OFS_FILTER, 32'h6);
		frame(16'h0025, 2, -1, 3'h2, 1, 0);
		cam.buf_fill <= 16'h0004;
		repeat (4) @(posedge aclk);
		rdchk(`FBO_OFS_STATUS, 32'h19, `FBO_RESP_OKAY);
		wr(`FBO_OFS_FILTER, 32'h6);
		frame(16'h0023, 2, -1, 3'h4, 1, 2);
		summarize();
	end
endmodule : tb_frame_buffer_overflow_control
